/* File: idbpc_arb.sv */
// DMA channel arbiter holding one grant and its acknowledge.
`timescale 1ns/1ns
`default_nettype none
module idbpc_arb (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] req,
  input  wire logic       release_grant,
  output logic            grant_valid,
  output logic      [2:0] grant_chan,
  output logic      [7:0] ack_n
);
  // Lowest channel wins; the cascade channel never competes.
  function automatic logic [2:0] pick(input logic [7:0] r);
    logic [2:0] c;
    c = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (r[i] && 3'(i) != idbpc_pkg::CASCADE_CHAN) begin
        c = 3'(i);
      end
    end
    return c;
  endfunction : pick

  logic [7:0] live_req;
  logic       take;
  logic [2:0] pick_chan;

  assign live_req  = req & ~(8'h01 << idbpc_pkg::CASCADE_CHAN);
  assign take      = !grant_valid && (|live_req);
  assign pick_chan = pick(live_req);

  // A grant stands until released, so only one acknowledge is ever low.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      grant_valid <= 1'b0;
      grant_chan  <= 3'h0;
      ack_n       <= 8'hff;
    end else if (take) begin
      grant_valid <= 1'b1;
      grant_chan  <= pick_chan;
      ack_n       <= ~(8'h01 << pick_chan);
    end else if (release_grant) begin
      grant_valid <= 1'b0;
      ack_n       <= 8'hff;
    end
  end
endmodule : idbpc_arb
`default_nettype wire

/* File: idbpc_isa_dev.sv */
// Model of the ISA peripherals: DMA requests and the ready line.
`timescale 1ns/1ns
`default_nettype none
module idbpc_isa_dev (
  input  wire logic       clk,
  input  wire logic [7:0] want,
  input  wire logic       slow,
  input  wire logic [7:0] dack_n,
  input  wire logic       tc,
  output logic      [7:0] dreq,
  output logic            rdy
);
  logic [7:0] done_reg = 8'h00;
  logic [3:0] cnt_reg  = 4'h0;
  // A channel asks until terminal count closes its block.
  assign dreq = want & ~done_reg;
  // Ready is pulled up; a slow device holds it low early, from its
  // acknowledge, so the synchronised level reaches the command phase.
  assign rdy = !(slow && |(want & ~dack_n) && cnt_reg < 4'h8);
  always_ff @(posedge clk) begin
    done_reg <= want & (done_reg | ({8{tc}} & ~dack_n));
    cnt_reg  <= |(want & ~dack_n) ? cnt_reg + {3'h0, cnt_reg != 4'hf} : 4'h0;
  end
endmodule : idbpc_isa_dev
`default_nettype wire

/* File: idbpc_monitor.sv */
// Concurrent assertions on the pins of the ISA DMA pin control block.
`timescale 1ns/1ns
`default_nettype none
module idbpc_monitor (
  input wire logic       CLK,
  input wire logic       RST_B,
  input wire logic       AEN,
  input wire logic       TC,
  input wire logic       MASTER_N,
  input wire logic [2:0] DMA_CHAN,
  input wire logic [7:0] DACK_N,
  input wire logic       SA_LO_OE,
  input wire logic [7:0] SA_LO_OUT,
  input wire logic       SBHE_N_OUT,
  input wire logic       SBHE_N_OE,
  input wire logic       IOCHRDY_OUT,
  input wire logic       IOCHRDY_OE,
  input wire logic [3:0] CMD_N_OUT,
  input wire logic       CMD_N_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // A command is active while the strobes are driven and one is low.
  wire cmd_act = CMD_N_OE && CMD_N_OUT != 4'hf;
  // Slow peripherals rely on at least three clocks of command.
  sequence cmd_three;
    cmd_act [*3];
  endsequence
  aen_drive_a: assert property (AEN |-> SA_LO_OE)
    else $error("AEN high without low address drive");
  master_aen_a: assert property (!MASTER_N [*5] |-> !AEN)
    else $error("AEN high during ISA master");
  tc_cmd_a: assert property (TC |-> cmd_act)
    else $error("TC outside a command phase");
  cmd_len_a: assert property ($rose(cmd_act) |-> cmd_three)
    else $error("command phase too short");
  sbhe_wide_a: assert property (SBHE_N_OE && DMA_CHAN > 3'h4 |-> !SBHE_N_OUT)
    else $error("SBHE high on a 16-bit channel");
  sbhe_byte_a: assert property (SBHE_N_OE && DMA_CHAN < 3'h4 |->
    SBHE_N_OUT == !SA_LO_OUT[0]) else $error("SBHE not inverse of A0");
  dack_one_a: assert property ($countones(~DACK_N) <= 1 && DACK_N[4])
    else $error("more than one acknowledge low");
  ready_wait_a: assert property (IOCHRDY_OE |-> !IOCHRDY_OUT ##1 !IOCHRDY_OE)
    else $error("ready wait not one clock low");
endmodule : idbpc_monitor
bind idbpc_top idbpc_monitor mon (.*);
`default_nettype wire

/* File: idbpc_pkg.sv */
// Shared constants, types and register map of the ISA DMA pin control block.
package idbpc_pkg;

  // ----------------------------------------------------------------------
  // Register map on the plain register port.
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG_CFG    = 8'h30;
  localparam logic [7:0] REG_STATUS = 8'h31;
  localparam logic [7:0] REG_PORT92 = 8'h92;
  localparam int unsigned PORT92_FAST_GATE_BIT = 1;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic       FAST_GATE_RESET = 1'b0;

  // ----------------------------------------------------------------------
  // Channel layout.
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CHAN      = 8;
  localparam logic [2:0]  LAST_8BIT_CHAN = 3'h3;
  localparam logic [2:0]  CASCADE_CHAN   = 3'h4;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned ADDR_TIME_NS  = 100;
  localparam int unsigned CMD_TIME_NS   = 300;
  localparam logic [1:0]  ADDR_CLKS =
    2'((ADDR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [1:0]  CMD_CLKS =
    2'((CMD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [2:0]  STRAP_SETTLE = 3'h4;

  // ----------------------------------------------------------------------
  // Synchroniser reset levels: requests idle low, the others idle high.
  // ----------------------------------------------------------------------
  localparam logic [7:0] DREQ_RESET = 8'h00;
  localparam logic [4:0] MISC_RESET = 5'h1f;

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_CMD  = 2'b10,
    ST_END  = 2'b11
  } idbpc_state_e;

  // One transfer as handed over by the DMA core.
  typedef struct packed {
    logic [23:0] addr;
    logic        to_mem;
    logic        last;
  } idbpc_dma_req_s;

  // Software configuration, high bit first.
  typedef struct packed {
    logic dma_ws;
    logic a20_drive;
    logic alt19;
    logic alt18;
    logic alt17;
  } idbpc_cfg_s;

endpackage : idbpc_pkg

/* File: idbpc_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ns
`default_nettype none
module idbpc_sync #(
  parameter int unsigned W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  // A bit moves only once the second and third stages agree.
  assign q_next = (s2_reg ~^ s3_reg) & s3_reg | (s2_reg ^ s3_reg) & q;

  // The first stage feeds the second stage only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q      <= q_next;
    end
  end
endmodule : idbpc_sync
`default_nettype wire

/* File: idbpc_test.sv */
// Self-checking bench for the ISA DMA pin control block.
`timescale 1ns/1ns
`default_nettype none
module idbpc_test;
  // Driven inputs start idle; the test strap starts pulled low.
  logic CLK = 1'b0, RST_B = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, slow = 1'b0;
  logic HOLD_ACK = 1'b1, REFRESH_ACTIVE = 1'b0, DMA_REG_SEL = 1'b0, rdy;
  logic KBD_GATE = 1'b0, MASTER_N = 1'b1, EXTRA_MASTER_GRANT = 1'b1;
  logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00, REFRESH_ADDR = 8'h00;
  logic [7:0] want = 8'h00, DREQ, REG_RDATA, DACK_N, SA_LO_OUT, SA_LO_IN;
  logic [3:0] CMD_N_IN, CMD_N_OUT, A2023_IN, A2023_OUT;
  logic [2:0] hi_ext = 3'h7, DMA_CHAN, A1719_IN, A1719_OUT;
  logic [2:0] SA_HI_IN, SA_HI_OUT, SA_HI_OE;
  logic [1:0] A89_IN, A89_OUT;
  logic HOLD_REQ, CYCLE_DONE, TC, AEN, IOCHRDY_IN, IOCHRDY_OUT, IOCHRDY_OE;
  logic SBHE_N_OUT, SBHE_N_OE, CMD_N_OE, LOW_MEG_MEM_READ_N, SA_LO_OE;
  logic LOW_MEG_MEM_WRITE_N, A89_OE, A1719_OE, A2023_OE, TEST_MODE, strap;
  logic EXTRA_MASTER_REQUEST, INTERNAL_IO_DISABLE, ADDR20_MASK_IN;
  logic ADDR20_MASK_OUT, ADDR20_MASK_OE;
  idbpc_pkg::idbpc_dma_req_s DMA_REQ = '0;
  int mismatches = 0, checks_done = 0, cyc = 0;
  // Each shared line shows whoever drives it; the CPU side holds the rest.
  assign CMD_N_IN = CMD_N_OE ? CMD_N_OUT : 4'hf;
  assign A2023_IN = A2023_OE ? A2023_OUT : 4'h0;
  assign A1719_IN = A1719_OE ? A1719_OUT : 3'h5;
  assign A89_IN = A89_OE ? A89_OUT : 2'h0;
  assign SA_LO_IN = SA_LO_OE ? SA_LO_OUT : 8'h00;
  assign SA_HI_IN = (SA_HI_OE & SA_HI_OUT) | (~SA_HI_OE & hi_ext);
  assign IOCHRDY_IN = IOCHRDY_OE ? IOCHRDY_OUT : rdy;
  assign ADDR20_MASK_IN = ADDR20_MASK_OE ? ADDR20_MASK_OUT : strap;
  assign strap = 1'b0;
  idbpc_top dut (.*);
  idbpc_isa_dev isa (.clk(CLK), .want(want), .slow(slow), .dack_n(DACK_N),
    .tc(TC), .dreq(DREQ), .rdy(rdy));
  always #50 CLK = ~CLK;
  // The whole run needs well under two hundred clocks; a hang stops here.
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 1000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic chk(input string nm, input logic [39:0] s, e);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // One register write, or one read compared with its expected value.
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge CLK);
    REG_ADDR <= a;
    REG_WDATA <= d;
    {REG_WR, REG_RD} <= {w, !w};
    @(posedge CLK);
    {REG_WR, REG_RD} <= 2'b00;
    @(negedge CLK);
    if (!w) chk("rdata", REG_RDATA, d);
  endtask : acc
  // One single-cycle block, snapshotting the pins in its command phase.
  // A slow block also moves its data towards memory.
  task automatic xfer(input int ch, input logic [23:0] a, input logic s);
    logic [39:0] snap;
    logic        t;
    int          n;
    t = 1'b0;
    n = 0;
    @(posedge CLK);
    DMA_REQ <= '{a, s, 1'b1};
    slow <= s;
    want[ch] <= 1'b1;
    repeat (60) begin
      @(negedge CLK);
      if (CMD_N_OE && CMD_N_OUT != 4'hf) begin
        n++;
        t |= TC;
        snap = {AEN, HOLD_REQ, SBHE_N_OE, A1719_OE, A2023_OE, SBHE_N_OUT,
                CMD_N_OUT, A2023_OUT, A1719_OUT, A89_OUT, SA_LO_OUT, DACK_N,
                LOW_MEG_MEM_READ_N, LOW_MEG_MEM_WRITE_N, DMA_CHAN};
      end
      if (CYCLE_DONE) break;
    end
    @(posedge CLK);
    want[ch] <= 1'b0;
    chk("cycle", snap, {5'h1f, ch > 4 ? 1'b0 : !a[0], s ? 4'h9 : 4'h6,
        a[23:17], a[9:0], 8'(~(8'h01 << ch)), s | (|a[23:20]),
        !s | (|a[23:20]), 3'(ch)});
    chk("tc len", {t, s ? n > 3 : n == 3}, 2'h3);
    // A stale request may win one more grant while its synchroniser drains.
    repeat (4) @(negedge CLK);
    chk("release", {DACK_N, AEN}, 9'h1fe);
  endtask : xfer
  initial begin
    int n;
    repeat (4) @(posedge CLK);
    RST_B <= 1'b1;
    repeat (6) @(negedge CLK);
    chk("strap", {TEST_MODE, ADDR20_MASK_OE}, 2'h2);
    acc(1'b0, idbpc_pkg::REG_CFG, idbpc_pkg::CFG_RESET);
    acc(1'b0, 8'h55, 8'h00);
    acc(1'b1, idbpc_pkg::REG_CFG, 8'h08);
    repeat (3) @(negedge CLK);
    chk("drive", {TEST_MODE, ADDR20_MASK_OE}, 2'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK);
      KBD_GATE <= i[0];
      acc(1'b1, idbpc_pkg::REG_PORT92, {6'h00, i[1], 1'b0});
      acc(1'b0, idbpc_pkg::REG_PORT92, {6'h00, i[1], 1'b0});
      chk("mask", ADDR20_MASK_OUT, i[0] | i[1]);
    end
    xfer(1, 24'h00_0301, 1'b0);
    xfer(6, 24'h0a_a6b4, 1'b1);
    xfer(3, 24'hf0_1ffe, 1'b0);
    @(posedge CLK);
    REFRESH_ACTIVE <= 1'b1;
    REFRESH_ADDR <= 8'h3c;
    repeat (2) @(negedge CLK);
    chk("refresh", {AEN, SA_LO_OE, A89_OE | A1719_OE | A2023_OE | SBHE_N_OE,
        SA_LO_OUT}, 11'h63c);
    chk("upper", {SA_HI_OE, SA_HI_OUT}, 6'h3d);
    @(posedge CLK);
    REFRESH_ACTIVE <= 1'b0;
    MASTER_N <= 1'b0;
    repeat (6) @(negedge CLK);
    chk("master", {AEN, SA_HI_OE}, 4'h0);
    @(posedge CLK);
    MASTER_N <= 1'b1;
    hi_ext <= 3'h6;
    EXTRA_MASTER_GRANT <= 1'b0;
    acc(1'b1, idbpc_pkg::REG_CFG, 8'h1f);
    repeat (2) @(negedge CLK);
    chk("shared", {EXTRA_MASTER_REQUEST, INTERNAL_IO_DISABLE, SA_HI_OE,
        SA_HI_OUT[1]}, 6'h34);
    @(posedge CLK);
    DMA_REG_SEL <= 1'b1;
    n = 0;
    repeat (4) begin
      @(negedge CLK);
      n += IOCHRDY_OE;
    end
    chk("wait", n, 1);
    tally_and_finish();
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
endmodule : idbpc_test
`default_nettype wire

/* File: idbpc_top.sv */
// ISA-side DMA and address pin control, top level.
`timescale 1ns/1ns
`default_nettype none
module idbpc_top (
  input  wire logic                      CLK,
  input  wire logic                      RST_B,
  // Register port.
  input  wire logic                [7:0] REG_ADDR,
  input  wire logic                [7:0] REG_WDATA,
  input  wire logic                      REG_WR,
  input  wire logic                      REG_RD,
  output logic                     [7:0] REG_RDATA,
  // DMA core side.
  input  wire idbpc_pkg::idbpc_dma_req_s DMA_REQ,
  input  wire logic                      HOLD_ACK,
  output logic                           HOLD_REQ,
  output logic                     [2:0] DMA_CHAN,
  output logic                           CYCLE_DONE,
  input  wire logic                      REFRESH_ACTIVE,
  input  wire logic                [7:0] REFRESH_ADDR,
  input  wire logic                      DMA_REG_SEL,
  input  wire logic                      KBD_GATE,
  // ISA channel pins.
  input  wire logic                [7:0] DREQ,
  output logic                     [7:0] DACK_N,
  output logic                           TC,
  output logic                           AEN,
  input  wire logic                      MASTER_N,
  input  wire logic                      IOCHRDY_IN,
  output logic                           IOCHRDY_OUT,
  output logic                           IOCHRDY_OE,
  output logic                           SBHE_N_OUT,
  output logic                           SBHE_N_OE,
  // Command strobes {IOW, IOR, MEMW, MEMR}, all active low.
  input  wire logic                [3:0] CMD_N_IN,
  output logic                     [3:0] CMD_N_OUT,
  output logic                           CMD_N_OE,
  output logic                           LOW_MEG_MEM_READ_N,
  output logic                           LOW_MEG_MEM_WRITE_N,
  // Address pins.
  input  wire logic                [7:0] SA_LO_IN,
  output logic                     [7:0] SA_LO_OUT,
  output logic                           SA_LO_OE,
  input  wire logic                [1:0] A89_IN,
  output logic                     [1:0] A89_OUT,
  output logic                           A89_OE,
  input  wire logic                [2:0] A1719_IN,
  output logic                     [2:0] A1719_OUT,
  output logic                           A1719_OE,
  input  wire logic                [3:0] A2023_IN,
  output logic                     [3:0] A2023_OUT,
  output logic                           A2023_OE,
  // Shared upper ISA address pins, index 0 is bit 17.
  input  wire logic                [2:0] SA_HI_IN,
  output logic                     [2:0] SA_HI_OUT,
  output logic                     [2:0] SA_HI_OE,
  output logic                           EXTRA_MASTER_REQUEST,
  input  wire logic                      EXTRA_MASTER_GRANT,
  output logic                           INTERNAL_IO_DISABLE,
  // Address-bit-20 mask pin and test strap.
  input  wire logic                      ADDR20_MASK_IN,
  output logic                           ADDR20_MASK_OUT,
  output logic                           ADDR20_MASK_OE,
  output logic                           TEST_MODE
);

  // ----------------------------------------------------------------------
  // Input synchronisers.
  // ----------------------------------------------------------------------

  logic [7:0] dreq_s;
  logic [4:0] misc_s;
  logic       master_n_s;
  logic       rdy_s;
  logic       xreq_n_s;
  logic       io_sel_n_s;
  logic       strap_s;

  // Request, ready, master, shared-pin and strap levels cross into the clock domain before any decision uses them.
  idbpc_sync #(
    .W       (8),
    .RST_VAL (idbpc_pkg::DREQ_RESET)
  ) u_sync_dreq (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     (DREQ),
    .q     (dreq_s)
  );

  idbpc_sync #(
    .W       (5),
    .RST_VAL (idbpc_pkg::MISC_RESET)
  ) u_sync_misc (
    .clk   (CLK),
    .rst_b (RST_B),
    .d     ({ADDR20_MASK_IN, SA_HI_IN[2], SA_HI_IN[0], IOCHRDY_IN,
             MASTER_N}),
    .q     (misc_s)
  );

  assign master_n_s = misc_s[0];
  assign rdy_s      = misc_s[1];
  assign xreq_n_s   = misc_s[2];
  assign io_sel_n_s = misc_s[3];
  assign strap_s    = misc_s[4];

  // ----------------------------------------------------------------------
  // Configuration and registers.
  // ----------------------------------------------------------------------

  idbpc_pkg::idbpc_cfg_s cfg_reg;
  logic                  fast_gate_reg;
  logic                  test_mode_reg;
  logic                  strap_done_reg;
  logic [2:0]            strap_cnt_reg;
  logic [7:0]            rdata_reg;
  logic [7:0]            rdata_next;
  logic                  wr_cfg;
  logic                  wr_p92;

  assign wr_cfg = REG_WR && (REG_ADDR == idbpc_pkg::REG_CFG);
  assign wr_p92 = REG_WR && (REG_ADDR == idbpc_pkg::REG_PORT92);

  // Software writes to the configuration and fast gate.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      cfg_reg       <= idbpc_pkg::CFG_RESET;
      fast_gate_reg <= idbpc_pkg::FAST_GATE_RESET;
    end else begin
      if (wr_cfg) begin
        cfg_reg <= idbpc_pkg::idbpc_cfg_s'(REG_WDATA[4:0]);
      end
      if (wr_p92) begin
        fast_gate_reg <= REG_WDATA[idbpc_pkg::PORT92_FAST_GATE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Test strap.
  // ----------------------------------------------------------------------

  // The strap is read once the synchroniser has settled after release,
  // since a reset value must never come from the pin itself. The filter
  // output lags the pin by four edges, so the count waits one edge more.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      strap_cnt_reg  <= 3'h0;
      strap_done_reg <= 1'b0;
      test_mode_reg  <= 1'b0;
    end else if (cfg_reg.a20_drive) begin
      strap_done_reg <= 1'b1;
      test_mode_reg  <= 1'b0;
    end else if (!strap_done_reg) begin
      if (strap_cnt_reg == idbpc_pkg::STRAP_SETTLE) begin
        strap_done_reg <= 1'b1;
        test_mode_reg  <= !strap_s;
      end else begin
        strap_cnt_reg <= strap_cnt_reg + 3'h1;
      end
    end
  end

  assign TEST_MODE = test_mode_reg;

  // ----------------------------------------------------------------------
  // Channel arbitration.
  // ----------------------------------------------------------------------

  logic       grant_valid;
  logic [2:0] grant_chan;
  logic       release_grant;
  logic       chan_req;

  idbpc_arb u_arb (
    .clk           (CLK),
    .rst_b         (RST_B),
    .req           (dreq_s),
    .release_grant (release_grant),
    .grant_valid   (grant_valid),
    .grant_chan    (grant_chan),
    .ack_n         (DACK_N)
  );

  assign chan_req = dreq_s[grant_chan];
  assign HOLD_REQ = grant_valid;
  assign DMA_CHAN = grant_chan;

  // ----------------------------------------------------------------------
  // DMA cycle sequencer.
  // ----------------------------------------------------------------------

  idbpc_pkg::idbpc_state_e   state_reg;
  idbpc_pkg::idbpc_state_e   state_next;
  logic [1:0]                cnt_reg;
  logic [1:0]                cnt_next;
  idbpc_pkg::idbpc_dma_req_s req_reg;
  logic                      sbhe_n_reg;
  logic                      tc_reg;
  logic                      dma_own;
  logic                      dma_busy;
  logic                      start;
  logic                      is16;

  // A granted channel runs cycles only when no ISA master has taken over.
  assign dma_own  = grant_valid && HOLD_ACK && master_n_s;
  assign start    = (state_reg == idbpc_pkg::ST_IDLE) && dma_own && chan_req;
  assign dma_busy = (state_reg != idbpc_pkg::ST_IDLE);
  assign is16     = (grant_chan > idbpc_pkg::LAST_8BIT_CHAN);

  // The grant ends after the last cycle or once the request is withdrawn.
  assign release_grant =
    ((state_reg == idbpc_pkg::ST_END) && req_reg.last) ||
    ((state_reg == idbpc_pkg::ST_IDLE) && grant_valid && !chan_req);
  assign CYCLE_DONE = (state_reg == idbpc_pkg::ST_END);

  // Address phase, command phase stretched by ready, then end.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      idbpc_pkg::ST_IDLE: begin
        if (start) begin
          state_next = idbpc_pkg::ST_ADDR;
          cnt_next   = idbpc_pkg::ADDR_CLKS - 2'h1;
        end
      end
      idbpc_pkg::ST_ADDR: begin
        if (cnt_reg == 2'h0) begin
          state_next = idbpc_pkg::ST_CMD;
          cnt_next   = idbpc_pkg::CMD_CLKS - 2'h1;
        end else begin
          cnt_next = cnt_reg - 2'h1;
        end
      end
      idbpc_pkg::ST_CMD: begin
        if (cnt_reg != 2'h0) begin
          cnt_next = cnt_reg - 2'h1;
        end else if (rdy_s) begin
          state_next = idbpc_pkg::ST_END;
        end
      end
      idbpc_pkg::ST_END: begin
        state_next = idbpc_pkg::ST_IDLE;
      end
      default: begin
        state_next = idbpc_pkg::ST_IDLE;
      end
    endcase
  end

  // Transfer details are latched at the start so pins stay steady.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg  <= idbpc_pkg::ST_IDLE;
      cnt_reg    <= 2'h0;
      req_reg    <= '0;
      sbhe_n_reg <= 1'b1;
      tc_reg     <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      tc_reg    <= (state_next == idbpc_pkg::ST_CMD) && req_reg.last;
      if (start) begin
        req_reg    <= DMA_REQ;
        sbhe_n_reg <= is16 ? 1'b0 : !DMA_REQ.addr[0];
      end
    end
  end

  assign TC = tc_reg;

  // ----------------------------------------------------------------------
  // Address enable and byte-high enable.
  // ----------------------------------------------------------------------

  // An ISA master pulls the enable low even during its own refresh.
  assign AEN = (dma_busy || REFRESH_ACTIVE) && master_n_s;

  assign SBHE_N_OUT = sbhe_n_reg;
  assign SBHE_N_OE  = dma_busy;

  // ----------------------------------------------------------------------
  // Command strobes.
  // ----------------------------------------------------------------------

  logic in_cmd;

  // Memory-bound transfers read I/O and write memory, and the reverse.
  assign in_cmd    = (state_reg == idbpc_pkg::ST_CMD);
  assign CMD_N_OUT = !in_cmd        ? 4'hf :
                     req_reg.to_mem ? 4'h9 : 4'h6;
  assign CMD_N_OE  = dma_busy;

  // ----------------------------------------------------------------------
  // Ready output for DMA register accesses.
  // ----------------------------------------------------------------------

  logic sel_d_reg;
  logic ws_reg;

  // One wait state on the first cycle of each register access.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sel_d_reg <= 1'b0;
      ws_reg    <= 1'b0;
    end else begin
      sel_d_reg <= DMA_REG_SEL;
      ws_reg    <= DMA_REG_SEL && !sel_d_reg && cfg_reg.dma_ws;
    end
  end

  // The line is released as soon as the wait ends, never held high.
  assign IOCHRDY_OUT = 1'b0;
  assign IOCHRDY_OE  = ws_reg && !dma_busy;

  // ----------------------------------------------------------------------
  // Low address pins.
  // ----------------------------------------------------------------------

  assign SA_LO_OUT = REFRESH_ACTIVE ? REFRESH_ADDR : req_reg.addr[7:0];
  assign SA_LO_OE  = dma_busy || REFRESH_ACTIVE;
  assign A89_OUT   = req_reg.addr[9:8];
  assign A89_OE    = dma_busy;

  // ----------------------------------------------------------------------
  // Upper local and ISA address pins.
  // ----------------------------------------------------------------------

  logic [2:0] sa_hi_src;
  logic [2:0] alt_sel;
  logic [3:0] a_top;

  assign A1719_OUT = req_reg.addr[19:17];
  assign A1719_OE  = dma_busy;
  assign A2023_OUT = req_reg.addr[23:20];
  assign A2023_OE  = dma_busy;

  // Outside DMA the local bus feeds the ISA pins straight through.
  assign sa_hi_src = dma_busy ? req_reg.addr[19:17] : A1719_IN;
  assign alt_sel   = {cfg_reg.alt19, cfg_reg.alt18, cfg_reg.alt17};

  // Each shared pin is either an ISA address bit or its alternate use.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sa_hi
      if (gi == 1) begin : g_grant
        assign SA_HI_OUT[gi] = alt_sel[gi] ? EXTRA_MASTER_GRANT
                                           : sa_hi_src[gi];
        assign SA_HI_OE[gi]  = alt_sel[gi] || master_n_s;
      end else begin : g_in
        assign SA_HI_OUT[gi] = sa_hi_src[gi];
        assign SA_HI_OE[gi]  = !alt_sel[gi] && master_n_s;
      end
    end
  endgenerate

  assign EXTRA_MASTER_REQUEST = cfg_reg.alt17 && !xreq_n_s;
  assign INTERNAL_IO_DISABLE  = cfg_reg.alt19 && io_sel_n_s;

  // ----------------------------------------------------------------------
  // Low-megabyte memory strobes.
  // ----------------------------------------------------------------------

  logic [3:0] cmd_n;

  // These gate pin levels directly; a synchroniser would skew the strobe.
  assign a_top = dma_busy ? req_reg.addr[23:20] : A2023_IN;
  assign cmd_n = dma_busy ? CMD_N_OUT : CMD_N_IN;
  assign LOW_MEG_MEM_READ_N  = cmd_n[0] || (|a_top);
  assign LOW_MEG_MEM_WRITE_N = cmd_n[1] || (|a_top);

  // ----------------------------------------------------------------------
  // Address-bit-20 mask pin.
  // ----------------------------------------------------------------------

  assign ADDR20_MASK_OUT = KBD_GATE || fast_gate_reg;
  assign ADDR20_MASK_OE  = cfg_reg.a20_drive;

  // ----------------------------------------------------------------------
  // Register read-back.
  // ----------------------------------------------------------------------

  logic [7:0] status_val;

  assign status_val = {test_mode_reg, grant_valid, grant_chan, is16,
                       state_reg};

  // Unmapped addresses read as zero.
  assign rdata_next =
    !REG_RD                              ? 8'h00 :
    (REG_ADDR == idbpc_pkg::REG_CFG)     ? {3'h0, cfg_reg} :
    (REG_ADDR == idbpc_pkg::REG_STATUS)  ? status_val :
    (REG_ADDR == idbpc_pkg::REG_PORT92)  ? {6'h00, fast_gate_reg, 1'b0} :
                                           8'h00;

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign REG_RDATA = rdata_reg;

endmodule : idbpc_top
`default_nettype wire
